// ---- core/tw2_ctrl.sv ----
// Timer2 waveform control with AXI4-Lite register access
`timescale 1ns/1ps
module tw2_ctrl #(
  parameter int ADDR_W = tw2_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Crystal clock input pin
  input wire logic crystal_clock_pin,
  // Pin and port control
  output logic compare_out_b_pin,
  output logic compare_out_b_pin_oe,
  output logic compare_out_b_override,
  output logic force_match_a_strobe,
  output logic crystal_port_detach
);

  localparam logic [ADDR_W-1:0] A_CTRL_A = ADDR_W'(4 * tw2_pkg::IDX_CTRL_A);
  localparam logic [ADDR_W-1:0] A_CTRL_B = ADDR_W'(4 * tw2_pkg::IDX_CTRL_B);
  localparam logic [ADDR_W-1:0] A_CMP_A = ADDR_W'(4 * tw2_pkg::IDX_CMP_A);
  localparam logic [ADDR_W-1:0] A_CMP_B = ADDR_W'(4 * tw2_pkg::IDX_CMP_B);
  localparam logic [ADDR_W-1:0] A_COUNT = ADDR_W'(4 * tw2_pkg::IDX_COUNT);
  localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'(4 * tw2_pkg::IDX_CFG);

  function automatic tw2_pkg::tw2_wave_t wave_kind(input logic [2:0] m);
    unique case (m)
      tw2_pkg::WM_NORMAL: wave_kind = tw2_pkg::TW2_NORMAL;
      tw2_pkg::WM_CTC: wave_kind = tw2_pkg::TW2_CTC;
      tw2_pkg::WM_PHASE_FF, tw2_pkg::WM_PHASE_A: wave_kind = tw2_pkg::TW2_PHASE;
      tw2_pkg::WM_FAST_FF, tw2_pkg::WM_FAST_A: wave_kind = tw2_pkg::TW2_FAST;
      default: wave_kind = tw2_pkg::TW2_RSVD;
    endcase
  endfunction : wave_kind

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == A_CTRL_A) || (a == A_CTRL_B) || (a == A_CMP_A) ||
                 (a == A_CMP_B) || (a == A_COUNT) || (a == A_CFG);
  endfunction : addr_known

  function automatic logic tap_hit(input logic [2:0] sel, input logic [9:0] p);
    unique case (sel)
      3'h0: tap_hit = 1'b0;
      3'h1: tap_hit = 1'b1;
      3'h2: tap_hit = (p & tw2_pkg::TAP_8) == tw2_pkg::TAP_8;
      3'h3: tap_hit = (p & tw2_pkg::TAP_32) == tw2_pkg::TAP_32;
      3'h4: tap_hit = (p & tw2_pkg::TAP_64) == tw2_pkg::TAP_64;
      3'h5: tap_hit = (p & tw2_pkg::TAP_128) == tw2_pkg::TAP_128;
      3'h6: tap_hit = (p & tw2_pkg::TAP_256) == tw2_pkg::TAP_256;
      3'h7: tap_hit = (p & tw2_pkg::TAP_1024) == tw2_pkg::TAP_1024;
    endcase
  endfunction : tap_hit

  // Registers
  tw2_pkg::tw2_ctrl_a_t ctrl_a_ff;
  tw2_pkg::tw2_ctrl_b_t ctrl_b_ff;
  logic [7:0] cmp_a_buf_ff, cmp_b_buf_ff, cmp_a_ff, cmp_b_ff, cfg_ff;
  logic [7:0] cnt_ff;
  logic dir_down_ff;
  logic [9:0] presc_ff;
  logic xtal_s1_ff, xtal_s2_ff, xtal_s3_ff;
  logic oc_b_ff, oe_b_ff, ovr_b_ff, force_a_ff, force_b_ff, detach_ff;

  // Bus state
  logic aw_hold_ff, w_hold_ff, bvalid_ff, awready_ff, wready_ff, arready_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  logic [2:0] wave_sel;
  tw2_pkg::tw2_wave_t wave;
  logic is_pwm, src_tick, tick, at_top, at_bottom, match_b, cmp_b_is_top;
  logic [7:0] top_val, nxt_cnt;
  logic nxt_dir_down, nxt_oc_b;
  logic wr_do, ar_fire, wr_ok;
  logic nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
  logic [1:0] act_b;
  logic rd_was_b_ff;

  assign wave_sel = {ctrl_b_ff.waveform_select_high, ctrl_a_ff.waveform_select_low};
  assign wave = wave_kind(wave_sel);
  assign is_pwm = (wave == tw2_pkg::TW2_PHASE) || (wave == tw2_pkg::TW2_FAST);
  // Modes 2, 5 and 7 take TOP from compare A
  assign top_val = (wave_sel == tw2_pkg::WM_CTC || wave_sel[2]) ? cmp_a_ff : tw2_pkg::CNT_MAX;
  assign at_top = cnt_ff == top_val;
  assign at_bottom = cnt_ff == tw2_pkg::CNT_BOTTOM;
  assign act_b = ctrl_a_ff.out_b_match_action;
  assign cmp_b_is_top = cmp_b_ff == top_val;

  // Crystal pin crossing; edge detect reads only the second stage onward
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xtal_s1_ff <= 1'b0;
      xtal_s2_ff <= 1'b0;
      xtal_s3_ff <= 1'b0;
    end else begin
      xtal_s1_ff <= crystal_clock_pin;
      xtal_s2_ff <= xtal_s1_ff;
      xtal_s3_ff <= xtal_s2_ff;
    end
  end

  assign src_tick = cfg_ff[tw2_pkg::CFG_ASYNC_BIT] ? (xtal_s2_ff & ~xtal_s3_ff) : 1'b1;
  assign tick = src_tick && tap_hit(ctrl_b_ff.clock_tap_select, presc_ff);
  assign match_b = tick && (cnt_ff == cmp_b_ff);

  // Shared prescaler runs free on the source clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_ff <= 10'h000;
    end else if (src_tick) begin
      presc_ff <= presc_ff + 10'h001;
    end
  end

  // Counting sequence; forced matches never reach this logic
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir_down = dir_down_ff;
    if (tick) begin
      unique case (wave)
        tw2_pkg::TW2_CTC, tw2_pkg::TW2_FAST: begin
          nxt_cnt = at_top ? tw2_pkg::CNT_BOTTOM : cnt_ff + 8'h01;
        end
        tw2_pkg::TW2_PHASE: begin
          if (!dir_down_ff) begin
            nxt_dir_down = at_top;
            nxt_cnt = at_top ? cnt_ff - 8'h01 : cnt_ff + 8'h01;
          end else begin
            nxt_dir_down = !at_bottom;
            nxt_cnt = at_bottom ? cnt_ff + 8'h01 : cnt_ff - 8'h01;
          end
        end
        default: begin
          nxt_cnt = cnt_ff + 8'h01;
          nxt_dir_down = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= tw2_pkg::CNT_BOTTOM;
      dir_down_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      dir_down_ff <= nxt_dir_down;
    end
  end

  // Compare update point per mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp_a_ff <= tw2_pkg::RST_CMP;
      cmp_b_ff <= tw2_pkg::RST_CMP;
    end else if (!is_pwm || (tick && at_top && (wave == tw2_pkg::TW2_FAST || !dir_down_ff))) begin
      cmp_a_ff <= cmp_a_buf_ff;
      cmp_b_ff <= cmp_b_buf_ff;
    end
  end

  // Output B waveform
  always_comb begin
    nxt_oc_b = oc_b_ff;
    unique case (wave)
      tw2_pkg::TW2_FAST: begin
        if (tick && at_top && act_b[1]) begin
          nxt_oc_b = !act_b[0];
        end else if (match_b && act_b[1] && !cmp_b_is_top) begin
          nxt_oc_b = act_b[0];
        end
      end
      tw2_pkg::TW2_PHASE: begin
        if (act_b[1] && cmp_b_is_top) begin
          if (tick && at_top && !dir_down_ff) begin
            nxt_oc_b = !act_b[0];
          end
        end else if (match_b && act_b[1]) begin
          nxt_oc_b = dir_down_ff ? !act_b[0] : act_b[0];
        end
      end
      default: begin
        if (match_b || force_b_ff) begin
          unique case (act_b)
            2'h1: nxt_oc_b = !oc_b_ff;
            2'h2: nxt_oc_b = 1'b0;
            2'h3: nxt_oc_b = 1'b1;
            default: nxt_oc_b = oc_b_ff;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oc_b_ff <= 1'b0;
      ovr_b_ff <= 1'b0;
      oe_b_ff <= 1'b0;
      detach_ff <= 1'b0;
    end else begin
      oc_b_ff <= nxt_oc_b;
      ovr_b_ff <= |act_b;
      oe_b_ff <= (|act_b) && cfg_ff[tw2_pkg::CFG_DIR_B_BIT];
      detach_ff <= cfg_ff[tw2_pkg::CFG_ASYNC_BIT];
    end
  end

  // Write channel: address and data taken in either order
  assign wr_do = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_ok = wr_do && wlane_ff;
  assign nxt_aw_hold = aw_hold_ff ? !wr_do : (awvalid && awready_ff);
  assign nxt_w_hold = w_hold_ff ? !wr_do : (wvalid && wready_ff);
  assign nxt_bvalid = bvalid_ff ? !bready : wr_do;
  assign ar_fire = arvalid && arready_ff;
  assign nxt_rvalid = rvalid_ff ? !rready : ar_fire;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= tw2_pkg::RESP_OKAY;
      awaddr_ff <= '0;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_hold && !nxt_bvalid;
      wready_ff <= !nxt_w_hold && !nxt_bvalid;
      if (awvalid && awready_ff) begin
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
      end
      if (wr_do) begin
        bresp_ff <= addr_known(awaddr_ff) ? tw2_pkg::RESP_OKAY : tw2_pkg::RESP_SLVERR;
      end
    end
  end

  // Register writes; reserved bits never stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_a_ff <= tw2_pkg::tw2_ctrl_a_t'(tw2_pkg::RST_CTRL);
      ctrl_b_ff <= tw2_pkg::tw2_ctrl_b_t'(tw2_pkg::RST_CTRL);
      cmp_a_buf_ff <= tw2_pkg::RST_CMP;
      cmp_b_buf_ff <= tw2_pkg::RST_CMP;
      cfg_ff <= tw2_pkg::RST_CFG;
    end else if (wr_ok) begin
      unique case (awaddr_ff)
        A_CTRL_A: begin
          ctrl_a_ff <= tw2_pkg::tw2_ctrl_a_t'(wbyte_ff);
          ctrl_a_ff.rsvd <= 2'h0;
        end
        A_CTRL_B: begin
          ctrl_b_ff <= tw2_pkg::tw2_ctrl_b_t'(wbyte_ff);
          ctrl_b_ff.force_match_a <= 1'b0;
          ctrl_b_ff.force_match_b <= 1'b0;
          ctrl_b_ff.rsvd <= 2'h0;
        end
        A_CMP_A: cmp_a_buf_ff <= wbyte_ff;
        A_CMP_B: cmp_b_buf_ff <= wbyte_ff;
        A_CFG: cfg_ff <= {6'h00, wbyte_ff[1:0]};
        default: ;
      endcase
    end
  end

  // Force strobes use the mode in force before this write lands
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      force_a_ff <= 1'b0;
      force_b_ff <= 1'b0;
    end else begin
      force_a_ff <= wr_ok && awaddr_ff == A_CTRL_B && wbyte_ff[7] && !is_pwm;
      force_b_ff <= wr_ok && awaddr_ff == A_CTRL_B && wbyte_ff[6] && !is_pwm;
    end
  end

  // Read channel
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= tw2_pkg::RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (ar_fire) begin
        rresp_ff <= addr_known(araddr) ? tw2_pkg::RESP_OKAY : tw2_pkg::RESP_SLVERR;
        unique case (araddr)
          A_CTRL_A: rdata_ff <= {24'h000000, ctrl_a_ff};
          A_CTRL_B: rdata_ff <= {24'h000000, ctrl_b_ff};
          A_CMP_A: rdata_ff <= {24'h000000, cmp_a_buf_ff};
          A_CMP_B: rdata_ff <= {24'h000000, cmp_b_buf_ff};
          A_COUNT: rdata_ff <= {24'h000000, cnt_ff};
          A_CFG: rdata_ff <= {24'h000000, cfg_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign compare_out_b_pin = oc_b_ff;
  assign compare_out_b_pin_oe = oe_b_ff;
  assign compare_out_b_override = ovr_b_ff;
  assign force_match_a_strobe = force_a_ff;
  assign crystal_port_detach = detach_ff;

  a_pin_override:
  assert property (@(posedge mclk) disable iff (rst)
    ##1 compare_out_b_override == $past(|ctrl_a_ff.out_b_match_action))
    else $error("override does not follow action field");

  a_pin_drive:
  assert property (@(posedge mclk) disable iff (rst)
    compare_out_b_pin_oe |-> $past(cfg_ff[tw2_pkg::CFG_DIR_B_BIT]) && compare_out_b_override)
    else $error("pin driven without output direction");

  a_nonpwm_toggle:
  assert property (@(posedge mclk) disable iff (rst)
    (!is_pwm && act_b == 2'h1 && match_b) |=> compare_out_b_pin != $past(compare_out_b_pin))
    else $error("toggle on match missing");

  a_fast_bottom:
  assert property (@(posedge mclk) disable iff (rst)
    (wave == tw2_pkg::TW2_FAST && act_b == 2'h2 && tick && at_top) |=> compare_out_b_pin && cnt_ff == 8'h00)
    else $error("fast mode did not set at bottom");

  a_phase_up:
  assert property (@(posedge mclk) disable iff (rst)
    (wave == tw2_pkg::TW2_PHASE && act_b == 2'h2 && match_b && !dir_down_ff && !cmp_b_is_top)
    |=> !compare_out_b_pin)
    else $error("phase mode up match did not clear");

  a_reserved_zero:
  assert property (@(posedge mclk) disable iff (rst)
    (ar_fire && (araddr == A_CTRL_A || araddr == A_CTRL_B)) |=> rdata[3:2] == 2'h0 || rd_was_b_ff)
    else $error("reserved bits read nonzero");

  // Remembers which control register the read data belongs to
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_was_b_ff <= 1'b0;
    end else if (ar_fire) begin
      rd_was_b_ff <= araddr == A_CTRL_B;
    end
  end

  a_force_read:
  assert property (@(posedge mclk) disable iff (rst)
    (rvalid && rd_was_b_ff) |-> rdata[7:4] == 4'h0)
    else $error("force or reserved bits read nonzero");

  a_force_pwm:
  assert property (@(posedge mclk) disable iff (rst)
    $rose(force_b_ff) |-> $past(!is_pwm))
    else $error("force acted in a PWM mode");

  a_force_count:
  assert property (@(posedge mclk) disable iff (rst)
    (force_b_ff && !tick) |=> cnt_ff == $past(cnt_ff))
    else $error("forced match moved the counter");

  a_clock_stop:
  assert property (@(posedge mclk) disable iff (rst)
    (ctrl_b_ff.clock_tap_select == 3'h0) [*2] |-> $stable(cnt_ff))
    else $error("counter moved while stopped");

endmodule : tw2_ctrl

// ---- core/tw2_pkg.sv ----
// Constants, types and register map of the timer2 waveform control block
// Operation
// - Nonzero output-B action field hands the pin to the compare output B.
// - Compare output B driver enabled only while its direction bit selects output.
// - Non-PWM: 00 disconnected, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 01 reserved, 10 clear match/set bottom, 11 set match/clear bottom.
// - Phase PWM: 01 reserved, 10 clear up-match/set down-match, 11 opposite.
// - Fast PWM with compare B at TOP: ignore match, act at BOTTOM.
// - Phase PWM with compare B at TOP: ignore match, act at TOP.
// - Reserved bits 3:2 of control A and 5:4 of control B read zero.
// - Waveform mode is high bit from control B plus two low bits from A.
// - Mode 0 normal TOP 0xFF; mode 2 clears at compare A; both immediate update.
// - Modes 1,5 phase PWM update at TOP; 3,7 fast update at BOTTOM; 4,6 reserved.
// - Force bits only act in non-PWM modes.
// - Force bit one gives an immediate match acted on by the action field.
// - Force bits are one-shot strobes using the action field present then.
// - Forced match raises no interrupt and never clears the counter.
// - Both force bits always read zero.
// - Clock select: 000 stop, 001 undivided, then divide 8,32,64,128,256,1024.
// - Timer clock is the I/O clock, or the crystal pin when async is selected.
package tw2_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'hb0;
  localparam logic [7:0] IDX_CTRL_B = 8'hb1;
  localparam logic [7:0] IDX_CMP_A = 8'hb2;
  localparam logic [7:0] IDX_CMP_B = 8'hb3;
  localparam logic [7:0] IDX_COUNT = 8'hb4;
  localparam logic [7:0] IDX_CFG = 8'hb5;

  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // Configuration register bit positions
  localparam int CFG_ASYNC_BIT = 0;
  localparam int CFG_DIR_B_BIT = 1;

  // Waveform mode codes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PHASE_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;

  // Prescaler tap masks for select codes 2..7
  localparam logic [9:0] TAP_8 = 10'h007;
  localparam logic [9:0] TAP_32 = 10'h01f;
  localparam logic [9:0] TAP_64 = 10'h03f;
  localparam logic [9:0] TAP_128 = 10'h07f;
  localparam logic [9:0] TAP_256 = 10'h0ff;
  localparam logic [9:0] TAP_1024 = 10'h3ff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] out_a_match_action;
    logic [1:0] out_b_match_action;
    logic [1:0] rsvd;
    logic [1:0] waveform_select_low;
  } tw2_ctrl_a_t;

  typedef struct packed {
    logic force_match_a;
    logic force_match_b;
    logic [1:0] rsvd;
    logic waveform_select_high;
    logic [2:0] clock_tap_select;
  } tw2_ctrl_b_t;

  typedef enum logic [2:0] {
    TW2_NORMAL,
    TW2_CTC,
    TW2_PHASE,
    TW2_FAST,
    TW2_RSVD
  } tw2_wave_t;

endpackage : tw2_pkg

// ---- dv/tw2_pad_model.sv ----
// Board-side model: pin B pad with pull-down and a gated crystal clock
`timescale 1ns/1ps
module tw2_pad_model #(
  parameter int HALF_NS = 70
) (
  // Design side
  input wire logic compare_out_b_pin,
  input wire logic compare_out_b_pin_oe,
  input wire logic crystal_port_detach,
  // Bench control
  input wire logic xtal_run,
  // Board side
  output logic pad_b,
  output logic crystal_clock_pin
);
  // Pull-down holds the pad low whenever the driver is off
  assign pad_b = compare_out_b_pin_oe ? compare_out_b_pin : 1'b0;
  // Crystal idles low until the port pins are handed over and a burst is requested
  initial begin
    crystal_clock_pin = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      if (xtal_run && crystal_port_detach) begin
        crystal_clock_pin = ~crystal_clock_pin;
      end else begin
        crystal_clock_pin = 1'b0;
      end
    end
  end
endmodule : tw2_pad_model

// ---- dv/timer2_waveform_control_test.sv ----
// Self-checking bench for the timer2 waveform control block
`timescale 1ns/1ps
module timer2_waveform_control_test;
  localparam logic [11:0] A_CTRLA = {2'h0, tw2_pkg::IDX_CTRL_A, 2'h0};
  localparam logic [11:0] A_CTRLB = {2'h0, tw2_pkg::IDX_CTRL_B, 2'h0};
  localparam logic [11:0] A_CMPA = {2'h0, tw2_pkg::IDX_CMP_A, 2'h0};
  localparam logic [11:0] A_CMPB = {2'h0, tw2_pkg::IDX_CMP_B, 2'h0};
  localparam logic [11:0] A_CNT = {2'h0, tw2_pkg::IDX_COUNT, 2'h0};
  localparam logic [11:0] A_CFG = {2'h0, tw2_pkg::IDX_CFG, 2'h0};
  typedef struct packed {logic [11:0] addr; logic [7:0] wd; logic [7:0] rd; logic [1:0] resp;} tw2_reg_row_t;
  typedef struct packed {logic [2:0] mode; logic [7:0] cmp_b; logic [1:0] act; int lo; int hi;} tw2_pwm_row_t;
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic crystal_clock_pin, compare_out_b_pin, compare_out_b_pin_oe, compare_out_b_override;
  logic force_match_a_strobe, crystal_port_detach, pad_b, xtal_run;
  logic [7:0] c0, c1;
  int errors = 0;
  int checks = 0;
  int hc, lo, hi;
  int fa_cnt = 0;
  int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] f_act [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic f_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  tw2_reg_row_t reg_rows [6] = '{'{A_CTRLA, 8'hff, 8'hf3, tw2_pkg::RESP_OKAY},
    '{A_CTRLB, 8'h3f, 8'h0f, tw2_pkg::RESP_OKAY}, '{A_CTRLB, 8'h00, 8'h00, tw2_pkg::RESP_OKAY},
    '{A_CTRLA, 8'h00, 8'h00, tw2_pkg::RESP_OKAY}, '{A_CMPB, 8'ha5, 8'ha5, tw2_pkg::RESP_OKAY},
    '{12'h3fc, 8'h12, 8'h00, tw2_pkg::RESP_SLVERR}};
  tw2_pwm_row_t pwm_rows [12] = '{'{3'h0, 8'h40, 2'h1, 512, 512}, '{3'h2, 8'h20, 2'h1, 512, 512},
    '{3'h3, 8'h40, 2'h2, 252, 268}, '{3'h3, 8'h40, 2'h3, 756, 772}, '{3'h1, 8'h40, 2'h2, 248, 266},
    '{3'h1, 8'h40, 2'h3, 758, 776}, '{3'h7, 8'h20, 2'h2, 256, 272}, '{3'h5, 8'h20, 2'h2, 246, 268},
    '{3'h3, 8'hff, 2'h2, 1024, 1024}, '{3'h3, 8'hff, 2'h3, 0, 0}, '{3'h1, 8'hff, 2'h2, 1024, 1024},
    '{3'h1, 8'hff, 2'h3, 0, 0}};

  tw2_ctrl i_dut (
    .mclk(mclk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .crystal_clock_pin(crystal_clock_pin),
    .compare_out_b_pin(compare_out_b_pin), .compare_out_b_pin_oe(compare_out_b_pin_oe),
    .compare_out_b_override(compare_out_b_override), .force_match_a_strobe(force_match_a_strobe),
    .crystal_port_detach(crystal_port_detach)
  );

  tw2_pad_model i_pad (
    .compare_out_b_pin(compare_out_b_pin), .compare_out_b_pin_oe(compare_out_b_pin_oe),
    .crystal_port_detach(crystal_port_detach), .xtal_run(xtal_run), .pad_b(pad_b),
    .crystal_clock_pin(crystal_clock_pin)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Strobe stands one cycle, so count it at every falling edge
  always @(negedge mclk) begin
    if (force_match_a_strobe === 1'b1) begin
      fa_cnt++;
    end
  end

  task final_report;
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Ready lines are registered, so the value at the falling edge is what the next rising edge sees
  task automatic tick_neg(inout int n);
    @(negedge mclk);
    n++;
    if (n > 200) begin
      errors++;
      final_report();
    end
  endtask : tick_neg

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : wait_cyc

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] resp);
    int n;
    logic aw_p, w_p, a_t, w_t, b_p;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    while (aw_p || w_p) begin
      tick_neg(n);
      a_t = aw_p && awready === 1'b1;
      w_t = w_p && wready === 1'b1;
      @(posedge mclk);
      if (a_t) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    bready <= 1'b1;
    b_p = 1'b1;
    while (b_p) begin
      tick_neg(n);
      if (bvalid === 1'b1) begin
        resp = bresp;
        b_p = 1'b0;
      end
      @(posedge mclk);
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    logic p;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    p = 1'b1;
    while (p) begin
      tick_neg(n);
      p = arready !== 1'b1;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    p = 1'b1;
    while (p) begin
      tick_neg(n);
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        p = 1'b0;
      end
      @(posedge mclk);
    end
    rready <= 1'b0;
  endtask : axi_rd

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, xtal_run} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    chk("reset_outs", {awready, wready, bvalid, arready, rvalid, compare_out_b_pin, compare_out_b_pin_oe,
      compare_out_b_override, force_match_a_strobe, crystal_port_detach}, 32'h0);
    @(posedge mclk);
    rst <= 1'b0;
    foreach (reg_rows[i]) begin
      axi_rd(reg_rows[i].addr, d, r);
      chk("reset_value", d, 32'h0);
    end
    foreach (reg_rows[i]) begin
      axi_wr(reg_rows[i].addr, reg_rows[i].wd, r);
      chk("wr_resp", r, reg_rows[i].resp);
      axi_rd(reg_rows[i].addr, d, r);
      chk("rd_data", d, {24'h0, reg_rows[i].rd});
      chk("rd_resp", r, reg_rows[i].resp);
    end
    axi_wr(A_CFG, 8'h02, r);
    axi_wr(A_CMPA, 8'h7f, r);
    foreach (pwm_rows[i]) begin
      axi_wr(A_CMPB, pwm_rows[i].cmp_b, r);
      axi_wr(A_CTRLA, {2'h0, pwm_rows[i].act, 2'h0, pwm_rows[i].mode[1:0]}, r);
      axi_wr(A_CTRLB, {4'h0, pwm_rows[i].mode[2], 3'h1}, r);
      wait_cyc(600);
      chk("override_on", compare_out_b_override, 32'h1);
      hc = 0;
      repeat (1024) begin
        @(negedge mclk);
        hc += int'(pad_b === 1'b1);
      end
      chk("high_count", hc >= pwm_rows[i].lo && hc <= pwm_rows[i].hi, 32'h1);
    end
    // Forced matches with the counter stopped, so only the strobe can move the pin
    axi_wr(A_CTRLB, 8'h00, r);
    foreach (f_act[i]) begin
      axi_wr(A_CTRLA, {2'h0, f_act[i], 4'h0}, r);
      axi_wr(A_CTRLB, 8'h40, r);
      wait_cyc(3);
      chk("forced_pin", pad_b, f_exp[i]);
      wait_cyc(10);
      chk("forced_once", pad_b, f_exp[i]);
    end
    axi_rd(A_CTRLB, d, r);
    chk("force_readback", d, 32'h0);
    axi_wr(A_CTRLA, 8'h33, r);
    axi_wr(A_CTRLB, 8'h40, r);
    wait_cyc(3);
    chk("pwm_force_ignored", pad_b, 32'h0);
    chk("oe_dir_out", compare_out_b_pin_oe, 32'h1);
    axi_wr(A_CFG, 8'h00, r);
    wait_cyc(2);
    chk("oe_dir_in", compare_out_b_pin_oe, 32'h0);
    chk("override_kept", compare_out_b_override, 32'h1);
    axi_wr(A_CTRLA, 8'h02, r);
    wait_cyc(2);
    chk("override_off", compare_out_b_override, 32'h0);
    axi_wr(A_CTRLB, 8'h01, r);
    wait_cyc(37);
    axi_wr(A_CTRLB, 8'h00, r);
    axi_rd(A_CNT, d, r);
    c0 = d[7:0];
    axi_wr(A_CTRLB, 8'h80, r);
    axi_rd(A_CNT, d, r);
    chk("ctc_force_no_clear", d[7:0], c0);
    chk("force_a_pulse", fa_cnt, 32'h1);
    axi_wr(A_CTRLA, 8'h00, r);
    for (int cs = 0; cs < 8; cs++) begin
      if (cs != 1) begin
        axi_wr(A_CTRLB, 8'(cs), r);
        axi_rd(A_CNT, d, r);
        c0 = d[7:0];
        wait_cyc(1000);
        axi_rd(A_CNT, d, r);
        c1 = d[7:0] - c0;
        lo = (cs == 0) ? 0 : 1000 / divs[cs];
        hi = (cs == 0) ? 0 : 1016 / divs[cs] + 1;
        chk("tap_rate", int'(c1) >= lo && int'(c1) <= hi, 32'h1);
      end
    end
    // Asynchronous source: counter must follow only crystal rising edges
    axi_wr(A_CTRLB, 8'h01, r);
    axi_wr(A_CFG, 8'h03, r);
    wait_cyc(4);
    chk("port_detach", crystal_port_detach, 32'h1);
    axi_rd(A_CNT, d, r);
    c0 = d[7:0];
    wait_cyc(20);
    axi_rd(A_CNT, d, r);
    chk("async_idle", d[7:0], c0);
    @(negedge mclk);
    xtal_run = 1'b1;
    #1400;
    xtal_run = 1'b0;
    wait_cyc(6);
    axi_rd(A_CNT, d, r);
    chk("async_ticks", d[7:0] - c0, 32'ha);
    final_report();
  end
endmodule : timer2_waveform_control_test
